//--- core/rcst_pkg.sv
// constants, encodings and register map of the reset cause and start-up block
// assumes a 100 MHz aclk that is also the core oscillator period
package rcst_pkg;

   // clock and start-up timing
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned PWRT_TIME_MS      = 72;
   localparam int unsigned PWRT_CYC_DEFAULT  = PWRT_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned OSC_START_PERIODS = 1024;
   localparam int unsigned OSC_START_CYC     = OSC_START_PERIODS;
   localparam int unsigned CNT_W             = 24;

   // oscillator mode encodings on the configuration input
   localparam logic [1:0] OSC_LP = 2'h0;
   localparam logic [1:0] OSC_XT = 2'h1;
   localparam logic [1:0] OSC_HS = 2'h2;
   localparam logic [1:0] OSC_RC = 2'h3;

   // register indices as printed, byte address is four times the index
   localparam int unsigned AXI_AW      = 12;
   localparam logic [7:0]  STATUS_IDX  = 8'h83;
   localparam logic [7:0]  POWER_CONTROL_IDX    = 8'h8e;
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
   localparam logic [11:0] POWER_CONTROL_ADDR   = {2'h0, POWER_CONTROL_IDX, 2'h0};

   // field positions
   localparam int unsigned ST_BANK_BIT = 5;
   localparam int unsigned ST_TO_BIT   = 4;
   localparam int unsigned ST_PD_BIT   = 3;
   localparam int unsigned PC_POR_BIT  = 1;

   // reset values
   localparam logic       POR_FLAG_RST = 1'b0;
   localparam logic       TO_FLAG_RST  = 1'b1;
   localparam logic       PD_FLAG_RST  = 1'b1;
   localparam logic [2:0] ALU_RST      = 3'h0;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      RCST_START,
      RCST_PWRT_WAIT,
      RCST_OSC_WAIT,
      RCST_RUN,
      RCST_SLEEP,
      RCST_WAKE_WAIT,
      RCST_HOLD
   } rcst_state_t;

endpackage : rcst_pkg

//--- core/rcst_top.sv
// reset cause flags, start-up delay and their axi4-lite register slave
// assumes aresetn is the power-on reset; pin and watchdog inputs are asynchronous
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

module rcst_top
   import rcst_pkg::*;
#(
   parameter int unsigned PWRT_CYCLES = PWRT_CYC_DEFAULT  // power-up timer length
)(
   input  wire logic              aclk,                // core clock
   input  wire logic              aresetn,             // power-on reset, sync, low
   input  wire logic              master_clear_pin_n,  // external reset pin, low
   input  wire logic              watchdog_timer_expire, // watchdog timeout level
   input  wire logic              sleep_cmd,           // core enters sleep, pulse
   input  wire logic              clear_watchdog_cmd,  // core clears watchdog, pulse
   input  wire logic [1:0]        osc_mode,            // oscillator mode config
   input  wire logic              powerup_timer_enable, // power-up timer config
   output logic                   core_reset,          // core held in reset
   output logic                   core_halted,         // core clock stopped
   output logic                   power_up_reset,      // last reset was power-up
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,        // write address
   input  wire logic              s_axi_awvalid,       // write address valid
   output logic                   s_axi_awready,       // write address ready
   input  wire logic [31:0]       s_axi_wdata,         // write data
   input  wire logic [3:0]        s_axi_wstrb,         // write byte enables
   input  wire logic              s_axi_wvalid,        // write data valid
   output logic                   s_axi_wready,        // write data ready
   output logic [1:0]             s_axi_bresp,         // write response
   output logic                   s_axi_bvalid,        // write response valid
   input  wire logic              s_axi_bready,        // write response ready
   input  wire logic [AXI_AW-1:0] s_axi_araddr,        // read address
   input  wire logic              s_axi_arvalid,       // read address valid
   output logic                   s_axi_arready,       // read address ready
   output logic [31:0]            s_axi_rdata,         // read data
   output logic [1:0]             s_axi_rresp,         // read response
   output logic                   s_axi_rvalid,        // read data valid
   input  wire logic              s_axi_rready         // read data ready
);

   typedef struct packed {
      rcst_state_t       st;
      logic [CNT_W-1:0]  cnt;
      logic              por_flag;
      logic              to_flag;
      logic              pd_flag;
      logic              bank;
      logic [2:0]        alu;
      logic              core_reset;
      logic              core_halted;
      logic              power_up_reset;
      logic              master_clear_pin_s1;
      logic              master_clear_pin_s2;
      logic              wdt_s1;
      logic              wdt_s2;
      logic              wdt_s3;
      logic              aw_held;
      logic              w_held;
      logic [AXI_AW-1:0] awaddr;
      logic [7:0]        wdata;
      logic              wstrb0;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } rcst_regs_t;

   rcst_regs_t s;
   rcst_regs_t next_s;

   logic wdt_evt;
   logic master_clear_pin_low;
   logic crystal;
   logic wr_go;
   logic power_control_wr;
   logic [AXI_AW-1:0] wr_word;
   logic [AXI_AW-1:0] rd_word;

   // word-aligned decode; the low two address bits are ignored
   assign wr_word  = {s.awaddr[AXI_AW-1:2], 2'h0};
   assign rd_word  = {s_axi_araddr[AXI_AW-1:2], 2'h0};
   // the pin feeds logic from its second synchroniser stage, the watchdog edge from its second and third
   assign wdt_evt  = s.wdt_s2 & ~s.wdt_s3;
   assign master_clear_pin_low = ~s.master_clear_pin_s2;
   assign crystal  = (osc_mode != OSC_RC);
   assign wr_go    = s.aw_held & s.w_held & ~s.bvalid;
   assign power_control_wr  = wr_go & s.wstrb0 & (wr_word == POWER_CONTROL_ADDR);

   // next state of flags, sequencer and bus slave
   always_comb
   begin
      next_s = s;
      next_s.master_clear_pin_s1 = master_clear_pin_n;
      next_s.master_clear_pin_s2 = s.master_clear_pin_s1;
      next_s.wdt_s1  = watchdog_timer_expire;
      next_s.wdt_s2  = s.wdt_s1;
      next_s.wdt_s3  = s.wdt_s2;

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s.awready)
      begin
         next_s.aw_held = 1'b1;
         next_s.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         next_s.w_held = 1'b1;
         next_s.wdata  = s_axi_wdata[7:0];
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;
      if (wr_go)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = RESP_OKAY;
         if (wr_word == STATUS_ADDR)
         begin
            // time-out and power-down are hardware owned, writes ignored
            if (s.wstrb0)
            begin
               next_s.bank = s.wdata[ST_BANK_BIT];
               next_s.alu  = s.wdata[2:0];
            end
         end
         else if (wr_word == POWER_CONTROL_ADDR)
         begin
            if (s.wstrb0)
               next_s.por_flag = s.wdata[PC_POR_BIT];
         end
         else
            next_s.bresp = RESP_SLVERR;
      end

      // read channel
      if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      if (s_axi_arvalid && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = 32'h0;
         if (rd_word == STATUS_ADDR)
         begin
            // bits 7..6 reserved, read zero
            next_s.rdata[ST_BANK_BIT] = s.bank;
            next_s.rdata[ST_TO_BIT]   = s.to_flag;
            next_s.rdata[ST_PD_BIT]   = s.pd_flag;
            next_s.rdata[2:0]         = s.alu;
         end
         else if (rd_word == POWER_CONTROL_ADDR)
            next_s.rdata[PC_POR_BIT] = s.por_flag;
         else
            next_s.rresp = RESP_SLVERR;
      end

      // start-up and reset-cause sequencer
      case (s.st)
         RCST_START:
         begin
            // rc always uses the power-up timer, crystals only when enabled
            if (powerup_timer_enable || !crystal)
            begin
               next_s.st  = RCST_PWRT_WAIT;
               next_s.cnt = CNT_W'(PWRT_CYCLES - 1);
            end
            else
            begin
               next_s.st  = RCST_OSC_WAIT;
               next_s.cnt = CNT_W'(OSC_START_CYC - 1);
            end
         end
         RCST_PWRT_WAIT:
         begin
            if (s.cnt == '0)
            begin
               if (crystal)
               begin
                  next_s.st  = RCST_OSC_WAIT;
                  next_s.cnt = CNT_W'(OSC_START_CYC - 1);
               end
               else
                  next_s.st = RCST_RUN;
            end
            else
               next_s.cnt = s.cnt - 1'b1;
         end
         RCST_OSC_WAIT, RCST_WAKE_WAIT:
         begin
            if (s.cnt == '0)
               next_s.st = RCST_RUN;
            else
               next_s.cnt = s.cnt - 1'b1;
         end
         RCST_RUN:
         begin
            if (wdt_evt)
            begin
               next_s.to_flag = 1'b0;
               next_s.st      = RCST_HOLD;
            end
            else if (sleep_cmd)
            begin
               next_s.to_flag = 1'b1;
               next_s.pd_flag = 1'b0;
               next_s.st      = RCST_SLEEP;
            end
            else if (clear_watchdog_cmd)
            begin
               next_s.to_flag = 1'b1;
               next_s.pd_flag = 1'b1;
            end
         end
         RCST_SLEEP:
         begin
            if (wdt_evt)
            begin
               // wake only, no reset of the core
               next_s.to_flag = 1'b0;
               next_s.pd_flag = 1'b0;
               if (crystal)
               begin
                  next_s.st  = RCST_WAKE_WAIT;
                  next_s.cnt = CNT_W'(OSC_START_CYC - 1);
               end
               else
                  next_s.st = RCST_RUN;
            end
         end
         RCST_HOLD:
         begin
            if (!master_clear_pin_low)
               next_s.st = RCST_RUN;
         end
         default:
            next_s.st = RCST_START;
      endcase

      // master clear wins over every other event
      if (master_clear_pin_low && s.st != RCST_HOLD)
      begin
         next_s.st = RCST_HOLD;
         if (s.st == RCST_SLEEP)
         begin
            next_s.to_flag = 1'b1;
            next_s.pd_flag = 1'b0;
         end
         else if (s.st == RCST_RUN)
         begin
            next_s.to_flag = s.to_flag;
            next_s.pd_flag = s.pd_flag;
         end
      end
      // every entry to hold is a non-power-up reset
      if (next_s.st == RCST_HOLD && s.st != RCST_HOLD)
      begin
         next_s.power_up_reset = 1'b0;
         next_s.bank           = 1'b0;
      end

      // registered outputs follow the next state
      next_s.core_reset  = (next_s.st == RCST_START) || (next_s.st == RCST_PWRT_WAIT) ||
                           (next_s.st == RCST_OSC_WAIT) || (next_s.st == RCST_HOLD);
      next_s.core_halted = (next_s.st == RCST_SLEEP) || (next_s.st == RCST_WAKE_WAIT);
      next_s.awready     = ~next_s.aw_held & ~next_s.bvalid;
      next_s.wready      = ~next_s.w_held & ~next_s.bvalid;
      next_s.arready     = ~next_s.rvalid;
   end

   // single register bank; reset is the power-on event
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s                <= '0;
         s.st             <= RCST_START;
         s.por_flag       <= POR_FLAG_RST;
         s.to_flag        <= TO_FLAG_RST;
         s.pd_flag        <= PD_FLAG_RST;
         s.alu            <= ALU_RST;
         s.core_reset     <= 1'b1;
         s.power_up_reset <= 1'b1;
         s.master_clear_pin_s1        <= 1'b1;
         s.master_clear_pin_s2        <= 1'b1;
         s.bresp          <= RESP_OKAY;
         s.rresp          <= RESP_OKAY;
      end
      else
         s <= next_s;
   end

   assign core_reset     = s.core_reset;
   assign core_halted    = s.core_halted;
   assign power_up_reset = s.power_up_reset;
   assign s_axi_awready  = s.awready;
   assign s_axi_wready   = s.wready;
   assign s_axi_bvalid   = s.bvalid;
   assign s_axi_bresp    = s.bresp;
   assign s_axi_arready  = s.arready;
   assign s_axi_rvalid   = s.rvalid;
   assign s_axi_rdata    = s.rdata;
   assign s_axi_rresp    = s.rresp;

   // checks run on aclk and are off while the power-on reset is held
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   por_flags_set_a: assert property ($past(!aresetn) |-> !s.por_flag && s.to_flag && s.pd_flag)
      else $error("power-on flag values wrong after reset");
   por_only_sw_a: assert property (!power_control_wr |=> $stable(s.por_flag))
      else $error("power-on flag changed without a write");
   por_write_a: assert property (power_control_wr |=> s.por_flag == $past(s.wdata[PC_POR_BIT]))
      else $error("power-on flag write lost");
   power_control_read_zero_a: assert property (s_axi_arvalid && s.arready && rd_word == POWER_CONTROL_ADDR
      |=> s.rvalid && s.rdata[31:2] == 30'h0 && !s.rdata[0] && s.rdata[1] == $past(s.por_flag))
      else $error("power control read shows reserved bits");
   osc_wait_len_a: assert property ($rose(s.st == RCST_OSC_WAIT || s.st == RCST_WAKE_WAIT)
      |-> s.cnt == CNT_W'(OSC_START_CYC - 1))
      else $error("oscillator wait loaded with wrong count");
   osc_wait_end_a: assert property ((s.st == RCST_OSC_WAIT) && s.cnt == '0 && !master_clear_pin_low
      |=> s.st == RCST_RUN && !s.core_reset)
      else $error("oscillator wait did not release core");
   master_clear_pin_run_keep_a: assert property (s.st == RCST_RUN && master_clear_pin_low
      |=> s.core_reset && $stable(s.to_flag) && $stable(s.pd_flag) && !s.power_up_reset)
      else $error("master clear while running changed flags");
   master_clear_pin_sleep_a: assert property (s.st == RCST_SLEEP && master_clear_pin_low
      |=> s.core_reset && s.to_flag && !s.pd_flag)
      else $error("master clear in sleep gave wrong flags");
   wdt_run_reset_a: assert property (s.st == RCST_RUN && wdt_evt && !master_clear_pin_low
      |=> s.core_reset && !s.to_flag && s.pd_flag == $past(s.pd_flag))
      else $error("watchdog reset gave wrong result");
   wdt_wake_a: assert property (s.st == RCST_SLEEP && wdt_evt && !master_clear_pin_low
      |=> !s.core_reset && !s.to_flag && !s.pd_flag && s.por_flag == $past(s.por_flag))
      else $error("watchdog wake gave wrong result");
   wdt_clears_to_a: assert property ((s.st == RCST_RUN || s.st == RCST_SLEEP) && wdt_evt
      && !master_clear_pin_low |=> !s.to_flag)
      else $error("watchdog expiry left time-out set");

endmodule : rcst_top

//--- sim/rcst_tb.sv
// self-checking bench for the reset cause flags and start-up delay block
// assumes rcst_pkg is compiled first; bench drives every port itself
`timescale 1ns/1ps

module tb;
   import rcst_pkg::*;

   // short power-up timer so that each crystal start-up stays near a thousand cycles
   localparam int unsigned PW = 20;

   logic        aclk;
   logic        aresetn;
   logic        master_clear_pin_n;
   logic        watchdog_timer_expire;
   logic        sleep_cmd;
   logic        clear_watchdog_cmd;
   logic [1:0]  osc_mode;
   logic        powerup_timer_enable;
   logic        core_reset;
   logic        core_halted;
   logic        power_up_reset;
   logic [11:0] s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [11:0] s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   int          errors;
   int          n_tests;

   rcst_top #(.PWRT_CYCLES(PW)) u_rcst_top (
      .aclk(aclk), .aresetn(aresetn), .master_clear_pin_n(master_clear_pin_n),
      .watchdog_timer_expire(watchdog_timer_expire), .sleep_cmd(sleep_cmd),
      .clear_watchdog_cmd(clear_watchdog_cmd), .osc_mode(osc_mode),
      .powerup_timer_enable(powerup_timer_enable), .core_reset(core_reset),
      .core_halted(core_halted), .power_up_reset(power_up_reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // 100 MHz core clock
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // hang guard, generous against roughly seven thousand cycles of tests
   initial
   begin
      #300000;
      errors++;
      end_of_test();
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // address and data offered together, each dropped at its own handshake
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int  k;
      bit  aw_done;
      bit  w_done;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_done = 0;
      w_done = 0;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1 && aw_done && w_done)
            break;
         if (!aw_done && s_axi_awready === 1'b1)
         begin
            s_axi_awvalid <= 1'b0;
            aw_done = 1;
         end
         if (!w_done && s_axi_wready === 1'b1)
         begin
            s_axi_wvalid <= 1'b0;
            w_done = 1;
         end
      end
      // a write that never answers counts as a mismatch
      check("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      // a read that never answers counts as a mismatch
      check("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_arvalid <= 1'b0;
   endtask : axi_read

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check("rdata", d, exp);
      check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rd_chk

   // power-on reset, then count cycles until the core is let go
   task automatic por(input logic [1:0] m, input logic pte);
      int n;
      int lo;
      @(posedge aclk);
      osc_mode <= m;
      powerup_timer_enable <= pte;
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      lo = 1 + ((pte || m == OSC_RC) ? PW : 0) + ((m == OSC_RC) ? 0 : OSC_START_CYC);
      n = 0;
      while (core_reset === 1'b1 && n < 5000)
      begin
         @(posedge aclk);
         n++;
      end
      check("startup_len_ok", {31'h0, n >= lo && n <= lo + 5}, 32'h1);
      check("power_up_reset", {31'h0, power_up_reset}, 32'h1);
   endtask : por

   // pin held low well past its synchroniser, then released
   task automatic master_clear_pin();
      int n;
      @(posedge aclk);
      master_clear_pin_n <= 1'b0;
      repeat (6) @(posedge aclk);
      check("master_clear_pin_core_reset", {31'h0, core_reset}, 32'h1);
      check("master_clear_pin_pur", {31'h0, power_up_reset}, 32'h0);
      master_clear_pin_n <= 1'b1;
      for (n = 0; n < 20 && core_reset !== 1'b0; n++)
         @(posedge aclk);
      check("master_clear_pin_release", {31'h0, core_reset}, 32'h0);
   endtask : master_clear_pin

   task automatic pulse_sleep();
      @(posedge aclk);
      sleep_cmd <= 1'b1;
      @(posedge aclk);
      sleep_cmd <= 1'b0;
      repeat (3) @(posedge aclk);
      check("halted", {31'h0, core_halted}, 32'h1);
   endtask : pulse_sleep

   // main sequence
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      errors = 0;
      n_tests = 0;
      aresetn = 1'b0;
      master_clear_pin_n = 1'b1;
      watchdog_timer_expire = 1'b0;
      sleep_cmd = 1'b0;
      clear_watchdog_cmd = 1'b0;
      osc_mode = OSC_XT;
      powerup_timer_enable = 1'b1;
      s_axi_awaddr = 12'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      por(OSC_XT, 1'b1);
      rd_chk(STATUS_ADDR, 32'h00000018);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000000);
      axi_write(POWER_CONTROL_ADDR, 32'hffffffff, RESP_OKAY);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000002);
      axi_write(STATUS_ADDR, 32'hffffffff, RESP_OKAY);
      rd_chk(STATUS_ADDR, 32'h0000003f);
      axi_write(STATUS_ADDR, 32'h00000000, RESP_OKAY);
      rd_chk(STATUS_ADDR, 32'h00000018);
      // unmapped places answer with an error and zero data
      axi_write(12'h000, 32'h00000002, RESP_SLVERR);
      axi_read(12'h004, d, r);
      check("unmapped_rdata", d, 32'h0);
      check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      // every oscillator mode, ending on a crystal mode for the wake tests
      for (int i = 3; i >= 0; i--)
      begin
         por(2'(i), 1'(i));
         rd_chk(POWER_CONTROL_ADDR, 32'h00000000);
         axi_write(POWER_CONTROL_ADDR, 32'h00000002, RESP_OKAY);
      end
      master_clear_pin();
      rd_chk(STATUS_ADDR, 32'h00000018);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000002);
      pulse_sleep();
      rd_chk(STATUS_ADDR, 32'h00000010);
      master_clear_pin();
      rd_chk(STATUS_ADDR, 32'h00000010);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000002);
      // watchdog expiry while asleep only wakes the core
      pulse_sleep();
      watchdog_timer_expire <= 1'b1;
      n = 0;
      while (core_halted === 1'b1 && n < 3000)
      begin
         @(posedge aclk);
         n++;
      end
      check("wake_len_ok", {31'h0, n >= OSC_START_CYC && n <= OSC_START_CYC + 8}, 32'h1);
      check("wake_no_reset", {31'h0, core_reset}, 32'h0);
      watchdog_timer_expire <= 1'b0;
      rd_chk(STATUS_ADDR, 32'h00000000);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000002);
      @(posedge aclk);
      clear_watchdog_cmd <= 1'b1;
      @(posedge aclk);
      clear_watchdog_cmd <= 1'b0;
      rd_chk(STATUS_ADDR, 32'h00000018);
      // watchdog expiry while running resets the core; fresh power-on first
      // so that the drop of power_up_reset is caused by the watchdog alone
      por(OSC_XT, 1'b0);
      axi_write(POWER_CONTROL_ADDR, 32'h00000002, RESP_OKAY);
      repeat (6) @(posedge aclk);
      watchdog_timer_expire <= 1'b1;
      for (n = 0; n < 10 && core_reset !== 1'b1; n++)
         @(posedge aclk);
      check("wdt_core_reset", {31'h0, core_reset}, 32'h1);
      repeat (5) @(posedge aclk);
      rd_chk(STATUS_ADDR, 32'h00000008);
      rd_chk(POWER_CONTROL_ADDR, 32'h00000002);
      check("wdt_pur", {31'h0, power_up_reset}, 32'h0);
      watchdog_timer_expire <= 1'b0;
      end_of_test();
   end

endmodule : tb
